// ===== motion_cmd_pkg.sv
// constants, codes and state type of the motion command decoder
// assumes the byte link and the motion core sit on the same system clock
package motion_cmd_pkg;

  // ****************************************************************
  // reply status codes
  // ****************************************************************
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_STORED = 8'h65;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_LOCKED = 8'h05;
  localparam logic [7:0] ST_UNAVAIL = 8'h06;

  // ****************************************************************
  // command numbers
  // ****************************************************************
  localparam logic [7:0] ROTATE_CW_CMD = 8'h01;
  localparam logic [7:0] ROTATE_CCW_CMD = 8'h02;
  localparam logic [7:0] MOTOR_HALT_CMD = 8'h03;
  localparam logic [7:0] MOVE_TO_TARGET_CMD = 8'h04;
  localparam logic [7:0] AXIS_PARAM_WRITE_CMD = 8'h05;
  localparam logic [7:0] AXIS_PARAM_READ_CMD = 8'h06;
  localparam logic [7:0] MODULE_PARAM_WRITE_CMD = 8'h09;
  localparam logic [7:0] MODULE_PARAM_READ_CMD = 8'h0A;
  localparam logic [7:0] USER_VAR_SAVE_CMD = 8'h0B;
  localparam logic [7:0] USER_VAR_RELOAD_CMD = 8'h0C;
  localparam logic [7:0] HOMING_SEARCH_CMD = 8'h0D;
  localparam logic [7:0] OUTPUT_PORT_WRITE_CMD = 8'h0E;
  localparam logic [7:0] INPUT_PORT_READ_CMD = 8'h0F;
  localparam logic [7:0] ACCU_CONST_ARITH_CMD = 8'h13;
  localparam logic [7:0] ACCU_COMPARE_CMD = 8'h14;
  localparam logic [7:0] PROGRAM_WAIT_CMD = 8'h1B;
  localparam logic [7:0] PROGRAM_END_CMD = 8'h1C;
  localparam logic [7:0] ACCU_XREG_ARITH_CMD = 8'h21;
  localparam logic [7:0] ACCU_TO_AXIS_PARAM_CMD = 8'h22;
  localparam logic [7:0] ACCU_TO_MODULE_PARAM_CMD = 8'h23;
  // existing commands that this decoder does not serve
  localparam logic [7:0] BRANCH_FIRST_CMD = 8'h15;
  localparam logic [7:0] BRANCH_LAST_CMD = 8'h1A;
  localparam logic [7:0] STORED_COORDINATE_TARGET_FIRST_CMD = 8'h1E;
  localparam logic [7:0] STORED_COORDINATE_TARGET_LAST_CMD = 8'h20;
  localparam logic [7:0] MISC_FIRST_CMD = 8'h24;
  localparam logic [7:0] MISC_LAST_CMD = 8'h27;

  // ****************************************************************
  // type field codes
  // ****************************************************************
  localparam logic [7:0] ABSOLUTE_TARGET = 8'h00;
  localparam logic [7:0] RELATIVE_TARGET = 8'h01;
  localparam logic [7:0] STORED_COORDINATE_TARGET = 8'h02;
  localparam logic [7:0] HOMING_QUERY = 8'h02;
  localparam logic [7:0] OP_ADD = 8'h00;
  localparam logic [7:0] OP_SUB = 8'h01;
  localparam logic [7:0] OP_MUL = 8'h02;
  localparam logic [7:0] OP_AND = 8'h05;
  localparam logic [7:0] OP_OR = 8'h06;
  localparam logic [7:0] OP_XOR = 8'h07;
  localparam logic [7:0] OP_NOT = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;
  localparam logic [7:0] USER_VAR_BANK = 8'h02;

  // ****************************************************************
  // framing and buffering
  // ****************************************************************
  localparam logic [3:0] LAST_BYTE = 4'h8;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;

  typedef enum logic [4:0] {
    S_RECV = 5'b00001,
    S_CHECK = 5'b00010,
    S_EXEC = 5'b00100,
    S_WAIT = 5'b01000,
    S_REPLY = 5'b10000
  } state_t;

endpackage : motion_cmd_pkg

// ===== motion_command_decoder.sv
// command frame decoder with reply builder and reply byte buffer
// assumes byte-wide receive and transmit streams and a motion core on CLK_SYS_I
// Contract
// - successful execution answers status 100.
// - command stored into program memory answers status 101.
// - bad checksum answers 1, unknown command number answers 2.
// - bad type answers 3, bad value 4, existing but unavailable 6.
// - config write while locked is refused with status 5.
// - numbers 1, 2, 3 rotate clockwise, counter-clockwise, halt a motor.
// - number 4 moves to absolute, relative or stored target by type.
// - numbers 5 and 6 write and read an axis parameter.
// - numbers 9 and 10 write and read a module parameter.
// - numbers 11 and 12 save and reload user variables only.
// - 13 homing search, 14 output port write, 15 input port read.
// - 19 accumulator arithmetic with value, 20 compare accumulator.
// - 33 accumulator arithmetic with the X register.
// - 34 and 35 copy accumulator to axis or module parameter.
// - 27 waits for condition or ticks, 28 ends the program.
// - frame is address, command, type, motor, value MSB first, checksum.
// - checksum is the 8-bit wrapping sum of all preceding bytes.
// - reply is reply address, module address, status, command, value, checksum.
// - transmit only in answer; host waits for each reply.
`timescale 1ns/1ps

// ******************************************************************
// reply byte buffer
// ******************************************************************
module reply_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_push = in_valid_i && in_ready_o;
  wire do_pop = out_valid_o && out_ready_i;

  // honest flags from the fill count
  assign in_ready_o = count != FULL_COUNT;
  assign out_valid_o = count != '0;
  assign out_data_o = mem[rd_ptr];

  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      case ({do_push, do_pop})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : reply_fifo

// ******************************************************************
// decoder top
// ******************************************************************
module motion_command_decoder (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] MODULE_ADDR_I,
  input wire logic [7:0] REPLY_ADDR_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic PROG_STORE_I,
  input wire logic CONFIG_LOCK_I,
  output logic CMD_VALID_O,
  output logic [7:0] CMD_NUM_O,
  output logic [7:0] CMD_TYPE_O,
  output logic [7:0] CMD_MOTOR_O,
  output logic [31:0] CMD_VALUE_O,
  input wire logic EXEC_DONE_I,
  input wire logic [7:0] EXEC_STATUS_I,
  input wire logic [31:0] EXEC_VALUE_I,
  output logic [31:0] ACCU_O
);
  motion_cmd_pkg::state_t state;
  logic [3:0] byte_cnt;
  logic [7:0] f_addr;
  logic [7:0] f_cmd;
  logic [7:0] f_type;
  logic [7:0] f_motor;
  logic [31:0] f_value;
  logic [7:0] f_sum;
  logic [7:0] f_chk;
  logic [31:0] xreg;
  logic [7:0] rep_status;
  logic [31:0] rep_value;
  logic [3:0] rep_idx;
  logic [7:0] rep_sum;
  logic fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;

  // ****************************************************************
  // frame checks
  // ****************************************************************
  wire rx_take = RX_VALID_I && RX_READY_O;
  wire addr_hit = f_addr == MODULE_ADDR_I;
  wire sum_bad = f_sum != f_chk;
  wire cmd_known = f_cmd inside {[motion_cmd_pkg::ROTATE_CW_CMD :
    motion_cmd_pkg::AXIS_PARAM_READ_CMD], [motion_cmd_pkg::MODULE_PARAM_WRITE_CMD :
    motion_cmd_pkg::INPUT_PORT_READ_CMD], motion_cmd_pkg::ACCU_CONST_ARITH_CMD,
    motion_cmd_pkg::ACCU_COMPARE_CMD, motion_cmd_pkg::PROGRAM_WAIT_CMD,
    motion_cmd_pkg::PROGRAM_END_CMD, [motion_cmd_pkg::ACCU_XREG_ARITH_CMD :
    motion_cmd_pkg::ACCU_TO_MODULE_PARAM_CMD]};
  wire cmd_unserved = f_cmd inside {[motion_cmd_pkg::BRANCH_FIRST_CMD :
    motion_cmd_pkg::BRANCH_LAST_CMD], [motion_cmd_pkg::STORED_COORDINATE_TARGET_FIRST_CMD :
    motion_cmd_pkg::STORED_COORDINATE_TARGET_LAST_CMD], [motion_cmd_pkg::MISC_FIRST_CMD :
    motion_cmd_pkg::MISC_LAST_CMD]};
  wire is_accu_const_arith_cmd = f_cmd == motion_cmd_pkg::ACCU_CONST_ARITH_CMD ||
    f_cmd == motion_cmd_pkg::ACCU_XREG_ARITH_CMD;
  wire is_internal = is_accu_const_arith_cmd || f_cmd == motion_cmd_pkg::ACCU_COMPARE_CMD;
  wire op_ok = f_type inside {motion_cmd_pkg::OP_ADD, motion_cmd_pkg::OP_SUB,
    motion_cmd_pkg::OP_MUL, motion_cmd_pkg::OP_AND, motion_cmd_pkg::OP_OR,
    motion_cmd_pkg::OP_XOR, motion_cmd_pkg::OP_NOT, motion_cmd_pkg::OP_LOAD};
  // type field limits per command
  wire type_bad = (f_cmd == motion_cmd_pkg::MOVE_TO_TARGET_CMD &&
    f_type > motion_cmd_pkg::STORED_COORDINATE_TARGET) ||
    (f_cmd == motion_cmd_pkg::HOMING_SEARCH_CMD && f_type > motion_cmd_pkg::HOMING_QUERY) ||
    (is_accu_const_arith_cmd && !op_ok);
  wire value_bad = (f_cmd == motion_cmd_pkg::USER_VAR_SAVE_CMD ||
    f_cmd == motion_cmd_pkg::USER_VAR_RELOAD_CMD) &&
    f_motor != motion_cmd_pkg::USER_VAR_BANK;
  wire lock_hit = CONFIG_LOCK_I && (f_cmd == motion_cmd_pkg::MODULE_PARAM_WRITE_CMD ||
    f_cmd == motion_cmd_pkg::USER_VAR_SAVE_CMD ||
    f_cmd == motion_cmd_pkg::ACCU_TO_MODULE_PARAM_CMD);

  // status priority, first failing check wins
  wire [7:0] check_status = sum_bad ? motion_cmd_pkg::ST_BAD_SUM :
    !cmd_known ? (cmd_unserved ? motion_cmd_pkg::ST_UNAVAIL :
    motion_cmd_pkg::ST_BAD_CMD) :
    type_bad ? motion_cmd_pkg::ST_BAD_TYPE :
    value_bad ? motion_cmd_pkg::ST_BAD_VALUE :
    lock_hit ? motion_cmd_pkg::ST_LOCKED :
    PROG_STORE_I ? motion_cmd_pkg::ST_STORED : motion_cmd_pkg::ST_OK;
  wire go_exec = check_status == motion_cmd_pkg::ST_OK && !is_internal;
  wire go_internal = check_status == motion_cmd_pkg::ST_OK && is_internal;

  // ****************************************************************
  // accumulator arithmetic
  // ****************************************************************
  wire [31:0] operand = f_cmd == motion_cmd_pkg::ACCU_XREG_ARITH_CMD ? xreg : f_value;
  wire [31:0] alu = f_type == motion_cmd_pkg::OP_ADD ? ACCU_O + operand :
    f_type == motion_cmd_pkg::OP_SUB ? ACCU_O - operand :
    f_type == motion_cmd_pkg::OP_MUL ? ACCU_O * operand :
    f_type == motion_cmd_pkg::OP_AND ? ACCU_O & operand :
    f_type == motion_cmd_pkg::OP_OR ? ACCU_O | operand :
    f_type == motion_cmd_pkg::OP_XOR ? ACCU_O ^ operand :
    f_type == motion_cmd_pkg::OP_NOT ? ~ACCU_O : operand;
  wire is_compare = f_cmd == motion_cmd_pkg::ACCU_COMPARE_CMD;
  wire xreg_load = f_cmd == motion_cmd_pkg::ACCU_XREG_ARITH_CMD &&
    f_type == motion_cmd_pkg::OP_LOAD;
  wire [31:0] next_accu = (is_compare || xreg_load) ? ACCU_O : alu;
  wire [31:0] internal_value = is_compare ? ACCU_O - f_value : next_accu;

  // reply byte for the current index
  wire [7:0] reply_byte = rep_idx == 4'h0 ? REPLY_ADDR_I :
    rep_idx == 4'h1 ? MODULE_ADDR_I :
    rep_idx == 4'h2 ? rep_status :
    rep_idx == 4'h3 ? f_cmd :
    rep_idx == 4'h4 ? rep_value[31:24] :
    rep_idx == 4'h5 ? rep_value[23:16] :
    rep_idx == 4'h6 ? rep_value[15:8] :
    rep_idx == 4'h7 ? rep_value[7:0] : rep_sum;
  wire push = state == motion_cmd_pkg::S_REPLY && fifo_in_ready;
  wire tx_load = fifo_out_valid && (!TX_VALID_O || TX_READY_I);

  // ****************************************************************
  // frame capture
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      byte_cnt <= 4'h0;
      f_addr <= 8'h00;
      f_cmd <= 8'h00;
      f_type <= 8'h00;
      f_motor <= 8'h00;
      f_value <= motion_cmd_pkg::VALUE_RESET;
      f_sum <= 8'h00;
      f_chk <= 8'h00;
    end else if (rx_take) begin
      byte_cnt <= byte_cnt == motion_cmd_pkg::LAST_BYTE ? 4'h0 : byte_cnt + 4'h1;
      f_sum <= byte_cnt == 4'h0 ? RX_DATA_I : f_sum + RX_DATA_I;
      case (byte_cnt)
        4'h0: f_addr <= RX_DATA_I;
        4'h1: f_cmd <= RX_DATA_I;
        4'h2: f_type <= RX_DATA_I;
        4'h3: f_motor <= RX_DATA_I;
        4'h8: begin
          f_chk <= RX_DATA_I;
          f_sum <= f_sum;
        end
        default: f_value <= {f_value[23:0], RX_DATA_I};
      endcase
    end
  end

  // ****************************************************************
  // sequence control
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state <= motion_cmd_pkg::S_RECV;
      RX_READY_O <= 1'b0;
      CMD_VALID_O <= 1'b0;
      rep_status <= 8'h00;
      rep_value <= motion_cmd_pkg::VALUE_RESET;
      rep_idx <= 4'h0;
      rep_sum <= 8'h00;
    end else begin
      CMD_VALID_O <= 1'b0;
      case (state)
        motion_cmd_pkg::S_RECV: begin
          RX_READY_O <= 1'b1;
          if (rx_take && byte_cnt == motion_cmd_pkg::LAST_BYTE) begin
            RX_READY_O <= 1'b0;
            state <= motion_cmd_pkg::S_CHECK;
          end
        end
        motion_cmd_pkg::S_CHECK: begin
          rep_status <= check_status;
          rep_value <= go_internal ? internal_value : f_value;
          rep_idx <= 4'h0;
          rep_sum <= 8'h00;
          if (!addr_hit) begin
            state <= motion_cmd_pkg::S_RECV;
          end else if (go_exec) begin
            state <= motion_cmd_pkg::S_EXEC;
          end else begin
            state <= motion_cmd_pkg::S_REPLY;
          end
        end
        motion_cmd_pkg::S_EXEC: begin
          CMD_VALID_O <= 1'b1;
          state <= motion_cmd_pkg::S_WAIT;
        end
        motion_cmd_pkg::S_WAIT: begin
          if (EXEC_DONE_I) begin
            rep_status <= EXEC_STATUS_I;
            rep_value <= EXEC_VALUE_I;
            state <= motion_cmd_pkg::S_REPLY;
          end
        end
        motion_cmd_pkg::S_REPLY: begin
          if (push) begin
            rep_idx <= rep_idx + 4'h1;
            rep_sum <= rep_sum + reply_byte;
            if (rep_idx == motion_cmd_pkg::LAST_BYTE) begin
              state <= motion_cmd_pkg::S_RECV;
            end
          end
        end
        default: state <= motion_cmd_pkg::S_RECV;
      endcase
    end
  end

  // command fields to the motion core
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      CMD_NUM_O <= 8'h00;
      CMD_TYPE_O <= 8'h00;
      CMD_MOTOR_O <= 8'h00;
      CMD_VALUE_O <= motion_cmd_pkg::VALUE_RESET;
    end else if (state == motion_cmd_pkg::S_CHECK) begin
      CMD_NUM_O <= f_cmd;
      CMD_TYPE_O <= f_type;
      CMD_MOTOR_O <= f_motor;
      CMD_VALUE_O <= f_value;
    end
  end

  // accumulator and X register
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ACCU_O <= motion_cmd_pkg::VALUE_RESET;
      xreg <= motion_cmd_pkg::VALUE_RESET;
    end else if (state == motion_cmd_pkg::S_CHECK && addr_hit && go_internal) begin
      ACCU_O <= next_accu;
      if (xreg_load) begin
        xreg <= ACCU_O;
      end
    end
  end

  // ****************************************************************
  // reply buffer and transmit stage
  // ****************************************************************
  reply_fifo #(
    .WIDTH(motion_cmd_pkg::FIFO_WIDTH),
    .DEPTH(motion_cmd_pkg::FIFO_DEPTH)
  ) u_reply_fifo (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .in_data_i(reply_byte),
    .in_valid_i(state == motion_cmd_pkg::S_REPLY),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!TX_VALID_O || TX_READY_I)
  );

  // output holding register
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      TX_VALID_O <= 1'b0;
      TX_DATA_O <= 8'h00;
    end else if (tx_load) begin
      TX_VALID_O <= 1'b1;
      TX_DATA_O <= fifo_out_data;
    end else if (TX_READY_I) begin
      TX_VALID_O <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_ok_status;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    state == motion_cmd_pkg::S_CHECK && addr_hit && go_internal |=> rep_status == 8'h64;
  endproperty
  a_ok_status: assert property (p_ok_status) else $error("internal success not 100");

  property p_stored;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    state == motion_cmd_pkg::S_CHECK && addr_hit && !sum_bad && cmd_known && !type_bad &&
      !value_bad && !lock_hit && PROG_STORE_I |=> rep_status == 8'h65 &&
      state == motion_cmd_pkg::S_REPLY;
  endproperty
  a_stored: assert property (p_stored) else $error("stored command not 101");

  property p_bad_sum;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    state == motion_cmd_pkg::S_CHECK && addr_hit && sum_bad |=> rep_status == 8'h01;
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("bad checksum not 1");

  property p_bad_cmd;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    state == motion_cmd_pkg::S_CHECK && !sum_bad && !cmd_known && !cmd_unserved |=>
      rep_status == 8'h02;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command not 2");

  property p_locked;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    state == motion_cmd_pkg::S_CHECK && addr_hit && !sum_bad && cmd_known && !type_bad &&
      !value_bad && lock_hit |=> rep_status == 8'h05 && !CMD_VALID_O ##1 !CMD_VALID_O;
  endproperty
  a_locked: assert property (p_locked) else $error("locked write not refused");

  property p_ignore;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    state == motion_cmd_pkg::S_CHECK && !addr_hit |=>
      state == motion_cmd_pkg::S_RECV && !push;
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign frame answered");

  property p_issue;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    state == motion_cmd_pkg::S_CHECK && addr_hit && go_exec |=>
      !CMD_VALID_O ##1 CMD_VALID_O && CMD_NUM_O == $past(f_cmd, 2) ##1 !CMD_VALID_O;
  endproperty
  a_issue: assert property (p_issue) else $error("command not issued once");

  property p_reply_sum;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    push && rep_idx == 4'h8 |-> reply_byte == 8'(REPLY_ADDR_I + MODULE_ADDR_I + rep_status +
      f_cmd + rep_value[31:24] + rep_value[23:16] + rep_value[15:8] + rep_value[7:0]);
  endproperty
  a_reply_sum: assert property (p_reply_sum) else $error("reply checksum wrong");

  property p_reply_head;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    push && rep_idx == 4'h2 |-> reply_byte == rep_status ##1 state != motion_cmd_pkg::S_RECV;
  endproperty
  a_reply_head: assert property (p_reply_head) else $error("reply order wrong");

  property p_answer_only;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    state == motion_cmd_pkg::S_RECV && !fifo_out_valid && !TX_VALID_O |=> !TX_VALID_O;
  endproperty
  a_answer_only: assert property (p_answer_only) else $error("unsolicited reply");

  property p_frame_len;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    rx_take && byte_cnt == 4'h8 |=> state == motion_cmd_pkg::S_CHECK && !RX_READY_O;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not closed at ninth byte");

endmodule : motion_command_decoder

// ===== motion_far_side.sv
// motion core and reply sink stand-in for the decoder bench
// assumes it shares the decoder's system clock
`timescale 1ns/1ps
module motion_far_side (
  input wire logic clk_i,
  input wire logic cmd_valid_i,
  input wire logic [31:0] cmd_value_i,
  output logic exec_done_o,
  output logic [7:0] exec_status_o,
  output logic [31:0] exec_value_o,
  output logic tx_ready_o
);
  int wait_cnt = -1;
  logic slow = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [31:0] held = 32'h0000_0000;
  initial begin
    exec_done_o = 1'b0;
    exec_status_o = 8'h00;
    exec_value_o = 32'h0000_0000;
    tx_ready_o = 1'b0;
  end
  // one answer per command, fast and slow in turn; sink stalls
  always @(posedge clk_i) begin
    phase <= phase + 2'h1;
    tx_ready_o <= (phase != 2'h0);
    exec_done_o <= 1'b0;
    exec_status_o <= ~exec_status_o; // junk outside the answer cycle
    exec_value_o <= ~exec_value_o;
    if (cmd_valid_i) begin
      wait_cnt <= slow ? 6 : 0;
      slow <= ~slow;
      held <= cmd_value_i + 32'h0000_0001;
    end else if (wait_cnt == 0) begin
      exec_done_o <= 1'b1;
      exec_status_o <= motion_cmd_pkg::ST_OK;
      exec_value_o <= held;
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : motion_far_side

// ===== test_motion_command_decoder.sv
// self-checking bench for the motion command decoder
// assumes motion_far_side plays motion core and reply sink
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module test_motion_command_decoder;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic store = 1'b0;
  logic lock = 1'b0;
  logic rx_ready, tx_valid, tx_ready, cmd_valid, exec_done;
  logic [7:0] tx_data, cmd_num, cmd_type, cmd_motor, exec_status;
  logic [31:0] cmd_value, exec_value, accu;
  logic [7:0] rep [9];
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  localparam logic [7:0] MOD = 8'h03;
  localparam logic [7:0] RADDR = 8'h02;
  always #2 clk = ~clk;
  motion_command_decoder motion_command_decoder_i (.CLK_SYS_I(clk), .RST_I(rst),
    .MODULE_ADDR_I(MOD), .REPLY_ADDR_I(RADDR), .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid),
    .RX_READY_O(rx_ready), .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
    .PROG_STORE_I(store), .CONFIG_LOCK_I(lock), .CMD_VALID_O(cmd_valid), .CMD_NUM_O(cmd_num),
    .CMD_TYPE_O(cmd_type), .CMD_MOTOR_O(cmd_motor), .CMD_VALUE_O(cmd_value),
    .EXEC_DONE_I(exec_done),
    .EXEC_STATUS_I(exec_status), .EXEC_VALUE_I(exec_value), .ACCU_O(accu));
  motion_far_side motion_far_side_i (.clk_i(clk), .cmd_valid_i(cmd_valid),
    .cmd_value_i(cmd_value), .exec_done_o(exec_done), .exec_status_o(exec_status),
    .exec_value_o(exec_value), .tx_ready_o(tx_ready));
  task automatic end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  // one frame, each byte held until taken; adj spoils the sum
  task automatic send(input logic [7:0] ad, cm, ty, mo, input logic [31:0] v,
                      input logic [7:0] adj);
    logic [7:0] b [9];
    b = '{ad, cm, ty, mo, v[31:24], v[23:16], v[15:8], v[7:0], adj};
    for (int i = 0; i < 8; i++) b[8] += b[i];
    for (int i = 0; i < 9; i++) begin
      rx_data <= b[i];
      rx_valid <= 1'b1;
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
  endtask : send
  // frame out, reply in, reply judged
  task automatic run_case(input logic [7:0] cm, ty, mo, input logic [31:0] v,
                          input logic [7:0] adj, st, input logic [31:0] ev);
    logic [7:0] s;
    send(MOD, cm, ty, mo, v, adj);
    for (int i = 0; i < 9; i++) begin
      do @(posedge clk); while (!(tx_valid === 1'b1 && tx_ready === 1'b1));
      rep[i] = tx_data;
    end
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += rep[i];
    `CHK("reply addr", RADDR, rep[0])
    `CHK("module addr", MOD, rep[1])
    `CHK("status", st, rep[2])
    `CHK("command", cm, rep[3])
    if (st != 8'h65) `CHK("value", ev, {rep[4], rep[5], rep[6], rep[7]})
    `CHK("checksum", s, rep[8])
  endtask : run_case
  // every served core command, varied type, fast and slow core
  task automatic t_core();
    logic [7:0] c [17] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0A, 8'h0B,
                           8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h1B, 8'h1C, 8'h22, 8'h23};
    for (int i = 0; i < 17; i++) begin
      run_case(c[i], 8'(i % 3), 8'h02, 32'h1234_5600 + i, 8'h00, 8'h64, 32'h1234_5601 + i);
      `CHK("issued cmd", c[i], cmd_num)
      `CHK("issued value", 32'h1234_5600 + i, cmd_value)
      `CHK("issued type", 8'(i % 3), cmd_type)
      `CHK("issued motor", 8'h02, cmd_motor)
    end
  endtask : t_core
  // error classes, lock and program store
  task automatic t_errors();
    run_case(8'h07, 8'h00, 8'h00, 32'h0000_0010, 8'h01, 8'h01, 32'h0000_0010);
    run_case(8'h07, 8'h00, 8'h00, 32'h0000_0011, 8'h00, 8'h02, 32'h0000_0011);
    run_case(8'h10, 8'h00, 8'h00, 32'h0000_0012, 8'h00, 8'h02, 32'h0000_0012);
    run_case(8'h15, 8'h00, 8'h00, 32'h0000_0013, 8'h00, 8'h06, 32'h0000_0013);
    run_case(8'h04, 8'h03, 8'h00, 32'h0000_0014, 8'h00, 8'h03, 32'h0000_0014);
    run_case(8'h0B, 8'h00, 8'h00, 32'h0000_0015, 8'h00, 8'h04, 32'h0000_0015);
    run_case(8'h0D, 8'h03, 8'h00, 32'h0000_0018, 8'h00, 8'h03, 32'h0000_0018);
    run_case(8'h0C, 8'h00, 8'h01, 32'h0000_0019, 8'h00, 8'h04, 32'h0000_0019);
    lock <= 1'b1;
    run_case(8'h09, 8'h00, 8'h00, 32'h0000_0016, 8'h00, 8'h05, 32'h0000_0016);
    run_case(8'h23, 8'h00, 8'h00, 32'h0000_001A, 8'h00, 8'h05, 32'h0000_001A);
    lock <= 1'b0;
    store <= 1'b1;
    run_case(8'h01, 8'h00, 8'h00, 32'h0000_0017, 8'h00, 8'h65, 32'h0000_0000);
    store <= 1'b0;
  endtask : t_errors
  // accumulator and X register arithmetic
  task automatic t_accu();
    run_case(8'h13, 8'h09, 8'h00, 32'h0000_0005, 8'h00, 8'h64, 32'h0000_0005);
    run_case(8'h13, 8'h00, 8'h00, 32'h0000_0003, 8'h00, 8'h64, 32'h0000_0008);
    run_case(8'h14, 8'h00, 8'h00, 32'h0000_0002, 8'h00, 8'h64, 32'h0000_0006);
    run_case(8'h21, 8'h09, 8'h00, 32'h0000_0000, 8'h00, 8'h64, 32'h0000_0008);
    run_case(8'h21, 8'h00, 8'h00, 32'h0000_0000, 8'h00, 8'h64, 32'h0000_0010);
    run_case(8'h13, 8'h01, 8'h00, 32'h0000_0004, 8'h00, 8'h64, 32'h0000_000C);
    run_case(8'h13, 8'h02, 8'h00, 32'h0000_0002, 8'h00, 8'h64, 32'h0000_0018);
    run_case(8'h13, 8'h05, 8'h00, 32'h0000_000F, 8'h00, 8'h64, 32'h0000_0008);
    run_case(8'h13, 8'h06, 8'h00, 32'h0000_0030, 8'h00, 8'h64, 32'h0000_0038);
    run_case(8'h13, 8'h07, 8'h00, 32'h0000_00FF, 8'h00, 8'h64, 32'h0000_00C7);
    run_case(8'h13, 8'h08, 8'h00, 32'h0000_0000, 8'h00, 8'h64, 32'hFFFF_FF38);
    run_case(8'h13, 8'h03, 8'h00, 32'h0000_0001, 8'h00, 8'h03, 32'h0000_0001);
    `CHK("accumulator", 32'hFFFF_FF38, accu)
  endtask : t_accu
  // frame for another module stays unanswered
  task automatic t_foreign();
    send(8'h05, 8'h01, 8'h00, 8'h00, 32'h0000_0001, 8'h00);
    repeat (30) begin
      @(posedge clk);
      `CHK("silent link", 1'b0, tx_valid)
    end
    run_case(8'h03, 8'h00, 8'h00, 32'h0000_0020, 8'h00, 8'h64, 32'h0000_0021);
  endtask : t_foreign
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_core();
    t_errors();
    t_accu();
    t_foreign();
    end_of_test();
  end
endmodule : test_motion_command_decoder
